//--- sccu_cfg.svh
// Purpose: constants of the system clock control unit
// Assumes: core_clk at 250 MHz, standby clock 32.768 kHz
// Notes: register offsets are byte addresses on APB
`ifndef SCCU_CFG_SVH
`define SCCU_CFG_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define SCCU_CLKCTL_OFS 12'h000
`define SCCU_GSTAT_OFS 12'h004
`define SCCU_GSET_OFS 12'h008
`define SCCU_GCLR_OFS 12'h00c
`define SCCU_OSCCS_OFS 12'h010
`define SCCU_RAW_OFS 12'h014
`define SCCU_MSK_OFS 12'h018
`define SCCU_SRCLR_OFS 12'h01c
`define SCCU_TRIM_OFS 12'h020
`define SCCU_RSTCTL_OFS 12'h024
// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define SCCU_INT_DIVIDER_RST 8'h04
`define SCCU_FRAC_DIVIDER_RST 8'h00
`define SCCU_NPERIPH 16
`define SCCU_GATE_RST 16'hfff0
`define SCCU_TRIM_MAX 4'h8
`define SCCU_RAW_LOSS 0
`define SCCU_RAW_SFAIL 1
`define SCCU_RAW_BLANK 2
`define SCCU_FRAC_ONE 17'h00100
// ----------------------------------------
// Timing
// ----------------------------------------
`define SCCU_CLK_HZ 250000000
`define SCCU_FOSC_HZ 64000000
`define SCCU_STBY_HZ 32768
`define SCCU_OWD_LO_HZ 50000000
`define SCCU_OWD_HI_HZ 68500000
`define SCCU_OWD_LO_CNT (`SCCU_OWD_LO_HZ / `SCCU_STBY_HZ)
`define SCCU_OWD_HI_CNT (`SCCU_OWD_HI_HZ / `SCCU_STBY_HZ)
`define SCCU_STBY_PER_CYC (`SCCU_CLK_HZ / `SCCU_STBY_HZ)
`define SCCU_OWD_SETTLE 2'h2
`define SCCU_VLOW_US 16
`define SCCU_VLOW_CYC ((`SCCU_VLOW_US * `SCCU_CLK_HZ) / 1000000)
`define SCCU_TRIM_US 5
`define SCCU_TRIM_CYC ((`SCCU_TRIM_US * `SCCU_CLK_HZ) / 1000000)
`endif

//--- sccu_pkg.sv
// Purpose: types of the system clock control unit
// Assumes: sccu_cfg.svh holds all numbers
// Notes: whole module state is one packed struct
`include "sccu_cfg.svh"
package sccu_pkg;
	typedef enum logic [1:0] {
		SCCU_OWD_IDLE = 2'b00,
		SCCU_OWD_SETTLE = 2'b01,
		SCCU_OWD_MEAS = 2'b10,
		SCCU_OWD_HOLD = 2'b11
	} sccu_owd_e;

	typedef struct packed {
		logic [1:0] osc_s;
		logic [1:0] sby_s;
		logic [1:0] drop_s;
		logic osc_d;
		logic sby_d;
		logic blank_d;
		logic [7:0] int_divider;
		logic [7:0] frac_divider;
		logic pdbl;
		logic drop_en;
		logic [16:0] acc;
		logic half;
		logic mclk_en;
		logic pclk_en;
		logic [`SCCU_NPERIPH-1:0] gate;
		logic [`SCCU_NPERIPH-1:0] pen;
		logic owd_en;
		logic lrst_en;
		logic slow;
		logic fast;
		logic sfail;
		sccu_owd_e ows;
		logic [1:0] settle;
		logic [11:0] ocnt;
		logic [14:0] scnt;
		logic [2:0] raw;
		logic [2:0] msk;
		logic sr0;
		logic sr1;
		logic rst_req;
		logic pd;
		logic [11:0] vcnt;
		logic [3:0] trim;
		logic prot;
		logic [11:0] tcnt;
		logic resp;
		logic [31:0] rdata;
		logic err;
	} sccu_state_s;
endpackage

//--- sccu_top.sv
// Purpose: system clock control unit: divider, blanking, watchdog, gating
// Assumes: fast_osc_out and standby_osc_out arrive as pins sampled by core_clk
// Notes: clocks leave as one-cycle enable pulses on core_clk
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "sccu_cfg.svh"
module sccu_top
	import sccu_pkg::*;
#(
	parameter logic [14:0] STBY_TO_CYC = 15'(2 * `SCCU_STBY_PER_CYC)
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fast_osc_out,
	input wire logic standby_osc_out,
	input wire logic core_supply_drop,
	input wire logic deep_sleep,
	output logic mclk_en,
	output logic pclk_en,
	output logic [`SCCU_NPERIPH-1:0] periph_clk_en,
	output logic critical_request,
	output logic common_request,
	output logic sys_reset_req,
	output logic fast_osc_pd,
	output logic [3:0] temp_trim_offset,
	output logic core_volt_low_flag,
	output logic trim_settling
);
	sccu_state_s st_r;
	sccu_state_s st_nxt;
	logic osc_tick;
	logic sby_tick;
	logic blank;
	logic on_stby;
	logic owd_on;
	logic acc_pulse;
	logic [16:0] div;
	logic [16:0] acc_sum;
	logic req_ph;
	logic wr;
	logic [31:0] rd;
	logic rd_err;

	// ----------------------------------------
	// Pin sampling and events
	// ----------------------------------------
	assign osc_tick = st_r.osc_s[1] & ~st_r.osc_d;
	assign sby_tick = st_r.sby_s[1] & ~st_r.sby_d;
	assign blank = st_r.drop_s[1] & st_r.drop_en;
	assign owd_on = st_r.owd_en & ~deep_sleep;
	// Outside deep sleep the standby clock only takes over while it is still alive; deep sleep always uses it
	assign on_stby = deep_sleep | ((st_r.slow | st_r.fast) & ~st_r.sfail);

	// ----------------------------------------
	// Fractional divider
	// ----------------------------------------
	// An integer part of zero would divide by the fraction alone; clamp to one
	assign div = ({1'b0, st_r.int_divider, st_r.frac_divider} < `SCCU_FRAC_ONE) ? `SCCU_FRAC_ONE
		: {1'b0, st_r.int_divider, st_r.frac_divider};
	assign acc_sum = st_r.acc + `SCCU_FRAC_ONE;
	assign acc_pulse = osc_tick & ~blank & (acc_sum >= div);

	// ----------------------------------------
	// APB access
	// ----------------------------------------
	// One wait state so that read data comes from a flip-flop
	assign req_ph = psel & penable & ~st_r.resp;
	assign pready = psel & penable & st_r.resp;
	assign wr = pready & pwrite;
	assign prdata = st_r.rdata;
	assign pslverr = st_r.err;

	always_comb begin
		rd = 32'h00000000;
		rd_err = 1'b0;
		case (paddr)
			`SCCU_CLKCTL_OFS: rd = {13'h0000, core_volt_low_flag, st_r.drop_en, st_r.pdbl,
				st_r.int_divider, st_r.frac_divider};
			`SCCU_GSTAT_OFS: rd = 32'(st_r.gate);
			`SCCU_GSET_OFS: rd = 32'h00000000;
			`SCCU_GCLR_OFS: rd = 32'h00000000;
			`SCCU_OSCCS_OFS: rd = {27'h0000000, st_r.sfail, st_r.fast, st_r.slow, 1'b0,
				st_r.owd_en};
			`SCCU_RAW_OFS: rd = {29'h00000000, st_r.raw};
			`SCCU_MSK_OFS: rd = {29'h00000000, st_r.msk};
			`SCCU_SRCLR_OFS: rd = 32'h00000000;
			`SCCU_TRIM_OFS: begin
				rd = {15'h0000, trim_settling, 7'h00, st_r.prot, 4'h0, st_r.trim};
				// Protected field: refuse writes while closed or out of range
				rd_err = pwrite & pwdata[8] == 1'b0 & ~st_r.prot
					& pwdata[3:0] != st_r.trim;
				if (pwrite && pwdata[3:0] > `SCCU_TRIM_MAX) begin
					rd_err = 1'b1;
				end
			end
			`SCCU_RSTCTL_OFS: rd = {31'h00000000, st_r.lrst_en};
			default: rd_err = 1'b1;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.osc_s = {st_r.osc_s[0], fast_osc_out};
		st_nxt.sby_s = {st_r.sby_s[0], standby_osc_out};
		st_nxt.drop_s = {st_r.drop_s[0], core_supply_drop};
		st_nxt.osc_d = st_r.osc_s[1];
		st_nxt.sby_d = st_r.sby_s[1];
		st_nxt.blank_d = blank;
		st_nxt.resp = req_ph;
		if (req_ph) begin
			st_nxt.rdata = rd;
			st_nxt.err = rd_err;
		end

		// Divider: pulses at twice mclk rate, every second one is mclk; pclk takes every pulse only with pdbl set
		st_nxt.mclk_en = 1'b0;
		st_nxt.pclk_en = 1'b0;
		if (on_stby) begin
			st_nxt.mclk_en = sby_tick;
			st_nxt.pclk_en = sby_tick;
		end else if (acc_pulse) begin
			st_nxt.half = ~st_r.half;
			st_nxt.mclk_en = st_r.half;
			st_nxt.pclk_en = st_r.pdbl | st_r.half;
		end
		if (osc_tick && !blank) begin
			st_nxt.acc = acc_pulse ? acc_sum - div : acc_sum;
		end
		st_nxt.pd = deep_sleep;

		// Oscillator watchdog
		if (st_r.scnt != STBY_TO_CYC) begin
			st_nxt.scnt = st_r.scnt + 15'h0001;
		end
		if (sby_tick) begin
			st_nxt.scnt = 15'h0000;
		end
		if (st_r.ocnt != 12'hfff && osc_tick) begin
			st_nxt.ocnt = st_r.ocnt + 12'h001;
		end
		case (st_r.ows)
			SCCU_OWD_IDLE: begin
				if (owd_on) begin
					st_nxt.ows = SCCU_OWD_SETTLE;
					st_nxt.settle = 2'h0;
				end
			end
			SCCU_OWD_SETTLE: begin
				if (sby_tick) begin
					st_nxt.settle = st_r.settle + 2'h1;
					st_nxt.ocnt = 12'h000;
					if (st_r.settle == `SCCU_OWD_SETTLE - 2'h1) begin
						st_nxt.ows = SCCU_OWD_MEAS;
					end
				end
			end
			SCCU_OWD_MEAS: begin
				if (sby_tick) begin
					st_nxt.ocnt = 12'h000;
					if (st_r.ocnt < 12'(`SCCU_OWD_LO_CNT)) begin
						st_nxt.slow = 1'b1;
						st_nxt.ows = SCCU_OWD_HOLD;
					end else if (st_r.ocnt > 12'(`SCCU_OWD_HI_CNT)) begin
						st_nxt.fast = 1'b1;
						st_nxt.ows = SCCU_OWD_HOLD;
					end else begin
						st_nxt.slow = 1'b0;
						st_nxt.fast = 1'b0;
					end
				end
			end
			SCCU_OWD_HOLD: st_nxt.ows = SCCU_OWD_HOLD;
			default: st_nxt.ows = SCCU_OWD_IDLE;
		endcase
		st_nxt.sfail = st_r.ows != SCCU_OWD_IDLE && st_r.scnt == STBY_TO_CYC;

		// Service requests: hardware set wins over software clear
		if (wr && paddr == `SCCU_SRCLR_OFS) begin
			st_nxt.raw = st_r.raw & ~pwdata[2:0];
		end
		// Every detection raises the event, also one repeated after a restart
		if (st_r.ows == SCCU_OWD_MEAS && st_nxt.ows == SCCU_OWD_HOLD) begin
			st_nxt.raw[`SCCU_RAW_LOSS] = 1'b1;
		end
		if (st_nxt.sfail & ~st_r.sfail) begin
			st_nxt.raw[`SCCU_RAW_SFAIL] = 1'b1;
		end
		// Blanking event is raised as clocks resume
		if (st_r.blank_d & ~blank) begin
			st_nxt.raw[`SCCU_RAW_BLANK] = 1'b1;
		end
		st_nxt.sr0 = st_r.raw[`SCCU_RAW_LOSS] & st_r.msk[`SCCU_RAW_LOSS];
		st_nxt.sr1 = |(st_r.raw[2:1] & st_r.msk[2:1]);
		st_nxt.rst_req = (st_r.slow | st_r.fast) & st_r.lrst_en;

		// Supply settle and trim settle counters
		if (st_r.vcnt != 12'h000) begin
			st_nxt.vcnt = st_r.vcnt - 12'h001;
		end
		if (st_r.tcnt != 12'h000) begin
			st_nxt.tcnt = st_r.tcnt - 12'h001;
		end
		if (blank) begin
			st_nxt.vcnt = 12'(`SCCU_VLOW_CYC);
		end

		// Register writes
		if (wr) begin
			case (paddr)
				`SCCU_CLKCTL_OFS: begin
					st_nxt.frac_divider = pwdata[7:0];
					st_nxt.int_divider = pwdata[15:8];
					st_nxt.pdbl = pwdata[16];
					st_nxt.drop_en = pwdata[17];
					st_nxt.vcnt = 12'(`SCCU_VLOW_CYC);
				end
				`SCCU_GSET_OFS: begin
					st_nxt.gate = st_r.gate | pwdata[`SCCU_NPERIPH-1:0];
					st_nxt.vcnt = 12'(`SCCU_VLOW_CYC);
				end
				`SCCU_GCLR_OFS: begin
					st_nxt.gate = st_r.gate & ~pwdata[`SCCU_NPERIPH-1:0];
					st_nxt.vcnt = 12'(`SCCU_VLOW_CYC);
				end
				`SCCU_OSCCS_OFS: begin
					st_nxt.owd_en = pwdata[0];
					if (pwdata[1] && st_r.owd_en) begin
						st_nxt.ows = SCCU_OWD_SETTLE;
						st_nxt.settle = 2'h0;
					end
				end
				`SCCU_MSK_OFS: st_nxt.msk = pwdata[2:0];
				`SCCU_TRIM_OFS: begin
					if (!st_r.err) begin
						st_nxt.prot = pwdata[8];
						if (st_r.prot && pwdata[3:0] != st_r.trim) begin
							st_nxt.trim = pwdata[3:0];
							st_nxt.tcnt = 12'(`SCCU_TRIM_CYC);
						end
					end
				end
				`SCCU_RSTCTL_OFS: st_nxt.lrst_en = pwdata[0];
				default: st_nxt.err = st_r.err;
			endcase
		end
		// Gate as it stands after this edge, so a new gate stops the very next pulse
		st_nxt.pen = st_nxt.mclk_en ? ~st_nxt.gate : '0;
		// Disabled or sleeping watchdog holds no status
		if (!owd_on) begin
			st_nxt.ows = SCCU_OWD_IDLE;
			st_nxt.slow = 1'b0;
			st_nxt.fast = 1'b0;
			st_nxt.sfail = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
			st_r.int_divider <= `SCCU_INT_DIVIDER_RST;
			st_r.frac_divider <= `SCCU_FRAC_DIVIDER_RST;
			st_r.drop_en <= 1'b1;
			st_r.gate <= `SCCU_GATE_RST;
			st_r.owd_en <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign mclk_en = st_r.mclk_en;
	assign pclk_en = st_r.pclk_en;
	assign periph_clk_en = st_r.pen;
	assign critical_request = st_r.sr0;
	assign common_request = st_r.sr1;
	assign sys_reset_req = st_r.rst_req;
	assign fast_osc_pd = st_r.pd;
	assign temp_trim_offset = st_r.trim;
	assign core_volt_low_flag = st_r.vcnt != 12'h000;
	assign trim_settling = st_r.tcnt != 12'h000;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_clk_wr;
		wr && paddr == `SCCU_CLKCTL_OFS;
	endsequence

	property p_div_apply;
		@(posedge core_clk) disable iff (!reset_n)
		s_clk_wr |=> st_r.int_divider == $past(pwdata[15:8]) && st_r.frac_divider == $past(pwdata[7:0]);
	endproperty
	a_div_apply: assert property (p_div_apply) else $error("divider not applied");

	property p_single;
		@(posedge core_clk) disable iff (!reset_n)
		(!on_stby && !st_r.pdbl) |=> pclk_en == mclk_en;
	endproperty
	a_single: assert property (p_single) else $error("pclk differs from mclk");

	property p_blank;
		@(posedge core_clk) disable iff (!reset_n)
		(blank && !on_stby) |=> !mclk_en && !pclk_en;
	endproperty
	a_blank: assert property (p_blank) else $error("clock ran while blanked");

	property p_lossrst;
		@(posedge core_clk) disable iff (!reset_n)
		(st_r.slow && st_r.lrst_en) |=> sys_reset_req;
	endproperty
	a_lossrst: assert property (p_lossrst) else $error("no reset on loss");

	property p_sleep;
		@(posedge core_clk) disable iff (!reset_n)
		deep_sleep |=> fast_osc_pd ##0 (mclk_en == $past(sby_tick));
	endproperty
	a_sleep: assert property (p_sleep) else $error("deep sleep clock wrong");

	property p_slow;
		@(posedge core_clk) disable iff (!reset_n)
		(st_r.ows == SCCU_OWD_MEAS && sby_tick && owd_on && !wr
			&& st_r.ocnt < 12'(`SCCU_OWD_LO_CNT)) |=> st_r.slow && st_r.raw[`SCCU_RAW_LOSS];
	endproperty
	a_slow: assert property (p_slow) else $error("slow osc not flagged");

	property p_gate;
		@(posedge core_clk) disable iff (!reset_n)
		(periph_clk_en & st_r.gate) == '0 && (!(|periph_clk_en) || mclk_en);
	endproperty
	a_gate: assert property (p_gate) else $error("gated peripheral clocked");

	property p_sr0;
		@(posedge core_clk) disable iff (!reset_n)
		(st_r.raw[`SCCU_RAW_LOSS] && st_r.msk[`SCCU_RAW_LOSS]) |=> critical_request;
	endproperty
	a_sr0: assert property (p_sr0) else $error("critical request missing");

	property p_owd_off;
		@(posedge core_clk) disable iff (!reset_n)
		!owd_on |=> st_r.ows == SCCU_OWD_IDLE && !st_r.slow && !st_r.fast;
	endproperty
	a_owd_off: assert property (p_owd_off) else $error("watchdog status kept");
endmodule // sccu_top
`default_nettype wire

//--- sccu_osc_model.sv
// Purpose: oscillator pins and clock consumer beside the clock unit
// Assumes: fast oscillator near 64 MHz, standby oscillator free running
// Notes: slow mode drops the fast oscillator to 40 MHz to provoke loss of clock
`timescale 1ns/100ps
`default_nettype none
module sccu_osc_model (
	input wire logic core_clk,
	input wire logic slow,
	input wire logic clr,
	input wire logic mclk_en,
	input wire logic pclk_en,
	output var logic fast_osc_out,
	output var logic standby_osc_out,
	output var int mcnt,
	output var int pcnt
);
	// ----------------------------------------
	// Oscillators
	// ----------------------------------------
	initial begin
		fast_osc_out = 1'b0;
		forever #(slow === 1'b1 ? 12.5 : 7.8) fast_osc_out = ~fast_osc_out;
	end
	// Standby clock runs free, as a real oscillator does
	initial begin
		standby_osc_out = 1'b0;
		forever #15258.8 standby_osc_out = ~standby_osc_out;
	end
	// ----------------------------------------
	// Clock consumer
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (clr) begin
			mcnt <= 0;
			pcnt <= 0;
		end else begin
			mcnt <= mcnt + int'(mclk_en);
			pcnt <= pcnt + int'(pclk_en);
		end
	end
endmodule // sccu_osc_model
`default_nettype wire

//--- sccu_top_bench.sv
// Purpose: self-checking bench of the system clock control unit
// Assumes: APB slave answers after one wait state
// Notes: watchdog cases run in real standby time, so they dominate run length
`timescale 1ns/100ps
`default_nettype none
`include "sccu_cfg.svh"
module sccu_top_bench;
	typedef struct {logic [11:0] a; logic [31:0] d; logic e;} sccu_row_s;
	logic core_clk, reset_n, psel, penable, pwrite, slow, clr, drop, sleep;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, err, mclk_en, pclk_en, crit, comm, sys_rst, fpd, vlow, tset;
	logic [15:0] pce;
	logic [3:0] trim;
	logic fosc, sosc;
	int mcnt, pcnt, error_cnt, check_count, n;
	sccu_row_s rows [7] = '{
		'{`SCCU_CLKCTL_OFS, 32'h00020400, 1'b0},
		'{`SCCU_GSTAT_OFS, 32'h0000fff0, 1'b0},
		'{`SCCU_OSCCS_OFS, 32'h00000001, 1'b0},
		'{`SCCU_RAW_OFS, 32'h00000000, 1'b0},
		'{`SCCU_TRIM_OFS, 32'h00000000, 1'b0},
		'{`SCCU_RSTCTL_OFS, 32'h00000000, 1'b0},
		'{12'h040, 32'h00000000, 1'b1}
	};
	sccu_top i_dut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fast_osc_out(fosc), .standby_osc_out(sosc),
		.core_supply_drop(drop), .deep_sleep(sleep), .mclk_en(mclk_en), .pclk_en(pclk_en),
		.periph_clk_en(pce), .critical_request(crit), .common_request(comm),
		.sys_reset_req(sys_rst), .fast_osc_pd(fpd), .temp_trim_offset(trim),
		.core_volt_low_flag(vlow), .trim_settling(tset));
	sccu_osc_model i_osc (.core_clk(core_clk), .slow(slow), .clr(clr), .mclk_en(mclk_en),
		.pclk_en(pclk_en), .fast_osc_out(fosc), .standby_osc_out(sosc), .mcnt(mcnt),
		.pcnt(pcnt));
	always #2 core_clk = ~core_clk;
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic stop_test;
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	// The request stands until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			chk("pready", 1, 0);
			stop_test();
		end
		// Let a write land before the caller looks at outputs
		@(negedge core_clk);
	endtask
	task automatic count(input int cyc);
		@(posedge core_clk);
		clr <= 1'b1;
		@(posedge core_clk);
		clr <= 1'b0;
		repeat (cyc) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		core_clk = 0;
		reset_n = 0;
		{psel, penable, pwrite, slow, clr, drop, sleep} = '0;
		paddr = '0;
		pwdata = '0;
		error_cnt = 0;
		check_count = 0;
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		foreach (rows[k]) begin
			apb(1'b0, rows[k].a, 32'h0);
			chk("rd", rows[k].d, rd);
			chk("err", 32'(rows[k].e), 32'(err));
		end
		count(1000);
		chk("mclk8", 1, 32'(mcnt inside {[30:34]}));
		chk("pclk8", 1, 32'(pcnt inside {[30:34]}));
		apb(1'b1, `SCCU_CLKCTL_OFS, 32'h00030200);
		chk("vlow", 1, 32'(vlow));
		count(1000);
		chk("mclk16", 1, 32'(mcnt inside {[62:66]}));
		chk("pclk32", 1, 32'(pcnt inside {[126:130]}));
		apb(1'b1, `SCCU_MSK_OFS, 32'h7);
		@(posedge core_clk);
		drop <= 1'b1;
		repeat (10) @(posedge core_clk);
		count(200);
		chk("blank", 0, mcnt);
		@(posedge core_clk);
		drop <= 1'b0;
		repeat (20) @(posedge core_clk);
		apb(1'b0, `SCCU_RAW_OFS, 32'h0);
		chk("blank_ev", 1, 32'(rd[2]));
		chk("comm", 1, 32'(comm));
		apb(1'b1, `SCCU_SRCLR_OFS, 32'h4);
		repeat (3) @(negedge core_clk);
		chk("comm_clr", 0, 32'(comm));
		apb(1'b1, `SCCU_GCLR_OFS, 32'h10);
		apb(1'b0, `SCCU_GSTAT_OFS, 32'h0);
		chk("gate", 32'h0000ffe0, rd);
		n = 0;
		while (mclk_en !== 1'b1 && n < 100) begin
			@(negedge core_clk);
			n++;
		end
		chk("pce", 32'h0000001f, 32'(pce));
		apb(1'b1, `SCCU_TRIM_OFS, 32'h100);
		apb(1'b1, `SCCU_TRIM_OFS, 32'h105);
		chk("trim", 5, 32'(trim));
		chk("tset", 1, 32'(tset));
		apb(1'b1, `SCCU_TRIM_OFS, 32'h109);
		chk("trim_err", 1, 32'(err));
		chk("trim_kept", 5, 32'(trim));
		apb(1'b1, `SCCU_RSTCTL_OFS, 32'h1);
		@(posedge core_clk);
		slow <= 1'b1;
		n = 0;
		while (crit !== 1'b1 && n < 20000) begin
			@(negedge core_clk);
			n++;
		end
		chk("crit", 1, 32'(crit));
		chk("sys_rst", 1, 32'(sys_rst));
		if (crit !== 1'b1) stop_test();
		apb(1'b0, `SCCU_OSCCS_OFS, 32'h0);
		chk("too_slow", 1, 32'(rd[2]));
		@(posedge core_clk);
		slow <= 1'b0;
		apb(1'b1, `SCCU_OSCCS_OFS, 32'h3);
		n = 0;
		do begin
			apb(1'b0, `SCCU_OSCCS_OFS, 32'h0);
			n++;
		end while (rd[3:2] !== 2'b00 && n < 8000);
		chk("recover", 0, 32'(rd[3:2]));
		apb(1'b1, `SCCU_SRCLR_OFS, 32'h1);
		repeat (3) @(negedge core_clk);
		chk("crit_clr", 0, 32'(crit));
		count(1000);
		chk("mclk_back", 1, 32'(mcnt inside {[62:66]}));
		@(posedge core_clk);
		sleep <= 1'b1;
		repeat (3) @(negedge core_clk);
		chk("osc_pd", 1, 32'(fpd));
		@(posedge core_clk);
		sleep <= 1'b0;
		stop_test();
	end
endmodule // sccu_top_bench
`default_nettype wire
